// >>> hw/rrs_pkg.sv
// ****************************************************************
// Shared constants for the return / rotate / subtract executor
// ****************************************************************
package rrs_pkg;

  // Timing: one instruction cycle is several system clocks
  localparam int CLK_PERIOD_NS = 50;
  localparam int INSTR_CYCLE_NS = 200;
  localparam int CLKS_PER_CYCLE = INSTR_CYCLE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CLKS_PER_CYCLE - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 2'h0;

  // Widths
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 15;
  localparam int ADDR_W = 5;

  // Register byte offsets on the Avalon slave
  localparam logic [ADDR_W-1:0] ADDR_ACC = 5'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 5'h08;
  localparam logic [ADDR_W-1:0] ADDR_STATE = 5'h0C;

  // Status field positions
  localparam int ST_CARRY = 0;
  localparam int ST_NIBBLE = 1;
  localparam int ST_ZERO = 2;
  localparam int ST_PD_N = 3;
  localparam int ST_TO_N = 4;

  // Control and state field positions
  localparam int CT_EXEC_EN = 0;
  localparam int SS_SLEEP = 0;
  localparam int SS_BUSY = 1;

  // Reset values
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] BYTE_ZERO = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Operation codes handed over by the instruction decoder
  typedef enum logic [2:0] {
    OP_NONE,
    OP_RETURN_LIT,
    OP_ROT_LEFT,
    OP_ROT_RIGHT,
    OP_LIT_SUB,
    OP_REG_SUB,
    OP_SLEEP
  } rrs_op_t;

endpackage

// >>> hw/rrs_exec.sv
// Notes on behaviour
// - Return-with-literal loads the 8-bit literal into the accumulator, flags untouched.
// - Return-with-literal pops the return stack and loads the PC from it.
// - Return-with-literal is one word and takes two instruction cycles.
// - Rotate left through carry: old carry to bit 0, bit 7 to carry.
// - Destination bit 0 writes the accumulator, 1 writes the addressed register.
// - Rotate right through carry: old carry to bit 7, bit 0 to carry.
// - Literal subtract computes literal minus accumulator into the accumulator.
// - Literal subtract: carry, nibble flag set unless accumulator larger; zero on zero.
// - Register subtract computes register minus accumulator, same flag updates.
// - Sleep clears the watchdog counter and its prescaler.
// - Sleep clears the power-down bit and sets the time-out bit.
// - Sleep halts execution and stops the oscillator until wake.
`timescale 1ns/1ps
`default_nettype none

module rrs_exec
  import rrs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Decoder side
  input wire logic instr_valid,
  input wire rrs_op_t instr_op,
  input wire logic [DATA_W-1:0] instr_literal,
  input wire logic [FADDR_W-1:0] instr_faddr,
  input wire logic instr_dest,
  output logic instr_ready,
  // Register file
  input wire logic [DATA_W-1:0] file_rdata,
  output logic file_we,
  output logic [FADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  // Return stack and program counter
  input wire logic [PC_W-1:0] stack_top,
  output logic stack_pop,
  output logic pc_load,
  output logic [PC_W-1:0] pc_value,
  // Watchdog, power and flags
  input wire logic watchdog_timeout,
  input wire logic wake_pin,
  output logic watchdog_counter_clear,
  output logic watchdog_prescaler_clear,
  output logic sleep_state,
  output logic osc_stop,
  output logic [DATA_W-1:0] accumulator,
  output logic carry,
  output logic nibble_borrow_inverse,
  output logic zero,
  output logic power_down_n,
  output logic watchdog_expiry_n
);

  // ****************************************************************
  // Subtract helper
  // ****************************************************************
  // Returns {carry, nibble flag, difference}; a flag is 1 when no borrow occurs
  function automatic logic [DATA_W+1:0] sub_flags(input logic [DATA_W-1:0] minu,
                                                  input logic [DATA_W-1:0] subt);
    logic [DATA_W:0] d;
    logic [4:0] n;
    d = {1'b0, minu} - {1'b0, subt};
    n = {1'b0, minu[3:0]} - {1'b0, subt[3:0]};
    return {~d[DATA_W], ~n[4], d[DATA_W-1:0]};
  endfunction

  logic [CNT_W-1:0] cnt;
  logic busy;
  logic exec_en;
  logic wake_meta;
  logic wake_sync;
  logic bus_ack;
  logic cycle_en;
  logic exec;
  logic access;
  logic wr_fire;
  logic wr_acc;
  logic wr_status;
  logic wr_ctrl;
  logic [31:0] rd_mux;
  logic [DATA_W+1:0] sub_lit;
  logic [DATA_W+1:0] sub_reg;
  logic [DATA_W-1:0] alu_res;
  logic to_acc;
  logic to_file;
  logic upd_c;
  logic upd_dz;
  logic new_c;
  logic new_dc;
  logic is_ret;
  logic is_sleep;

  // ****************************************************************
  // Instruction cycle divider and handshake
  // ****************************************************************
  // The divider is held while asleep, so execution resumes on a clean cycle
  assign cycle_en = (cnt == CNT_LAST) && !sleep_state;
  assign instr_ready = cycle_en && exec_en && !busy;
  assign exec = instr_valid && instr_ready;
  assign is_ret = exec && (instr_op == OP_RETURN_LIT);
  assign is_sleep = exec && (instr_op == OP_SLEEP);
  assign osc_stop = sleep_state;
  assign sub_lit = sub_flags(instr_literal, accumulator);
  assign sub_reg = sub_flags(file_rdata, accumulator);

  // Divider counter
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= CNT_ZERO;
    end else if (sleep_state || cnt == CNT_LAST) begin
      cnt <= CNT_ZERO;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end

  // ****************************************************************
  // Operation decode
  // ****************************************************************
  // Each operation picks its result, destination and flags to update
  always_comb begin
    alu_res = accumulator;
    to_acc = 1'b0;
    to_file = 1'b0;
    upd_c = 1'b0;
    upd_dz = 1'b0;
    new_c = carry;
    new_dc = nibble_borrow_inverse;
    if (exec) begin
      unique case (instr_op)
        OP_RETURN_LIT: begin
          alu_res = instr_literal;
          to_acc = 1'b1;
        end
        OP_ROT_LEFT: begin
          alu_res = {file_rdata[DATA_W-2:0], carry};
          new_c = file_rdata[DATA_W-1];
          upd_c = 1'b1;
          to_acc = !instr_dest;
          to_file = instr_dest;
        end
        OP_ROT_RIGHT: begin
          alu_res = {carry, file_rdata[DATA_W-1:1]};
          new_c = file_rdata[0];
          upd_c = 1'b1;
          to_acc = !instr_dest;
          to_file = instr_dest;
        end
        OP_LIT_SUB: begin
          alu_res = sub_lit[DATA_W-1:0];
          {new_c, new_dc} = sub_lit[DATA_W+1:DATA_W];
          upd_c = 1'b1;
          upd_dz = 1'b1;
          to_acc = 1'b1;
        end
        OP_REG_SUB: begin
          alu_res = sub_reg[DATA_W-1:0];
          {new_c, new_dc} = sub_reg[DATA_W+1:DATA_W];
          upd_c = 1'b1;
          upd_dz = 1'b1;
          to_acc = !instr_dest;
          to_file = instr_dest;
        end
        OP_NONE, OP_SLEEP: begin
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Accumulator and flags
  // ****************************************************************
  // The executing instruction wins over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      accumulator <= ACC_RST;
      carry <= 1'b0;
      nibble_borrow_inverse <= 1'b0;
      zero <= 1'b0;
    end else begin
      if (to_acc) begin
        accumulator <= alu_res;
      end else if (wr_acc) begin
        accumulator <= avs_writedata[DATA_W-1:0];
      end
      if (upd_c) begin
        carry <= new_c;
      end else if (wr_status) begin
        carry <= avs_writedata[ST_CARRY];
      end
      if (upd_dz) begin
        nibble_borrow_inverse <= new_dc;
        zero <= (alu_res == BYTE_ZERO);
      end else if (wr_status) begin
        nibble_borrow_inverse <= avs_writedata[ST_NIBBLE];
        zero <= avs_writedata[ST_ZERO];
      end
    end
  end

  // Power status bits; sleep wins over a watchdog expiry in the same cycle
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      power_down_n <= 1'b1;
      watchdog_expiry_n <= 1'b1;
    end else if (is_sleep) begin
      power_down_n <= 1'b0;
      watchdog_expiry_n <= 1'b1;
    end else if (watchdog_timeout) begin
      watchdog_expiry_n <= 1'b0;
    end
  end

  // ****************************************************************
  // Side outputs: file write, stack, watchdog
  // ****************************************************************
  // All pulses are registered and last one system clock
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      file_we <= 1'b0;
      file_waddr <= '0;
      file_wdata <= BYTE_ZERO;
      stack_pop <= 1'b0;
      pc_load <= 1'b0;
      pc_value <= PC_RST;
      watchdog_counter_clear <= 1'b0;
      watchdog_prescaler_clear <= 1'b0;
    end else begin
      file_we <= to_file;
      if (exec) begin
        file_waddr <= instr_faddr;
        file_wdata <= alu_res;
      end
      stack_pop <= is_ret;
      pc_load <= is_ret;
      if (is_ret) begin
        pc_value <= stack_top;
      end
      watchdog_counter_clear <= is_sleep;
      watchdog_prescaler_clear <= is_sleep;
    end
  end

  // ****************************************************************
  // Sequencing: two-cycle return, sleep and wake
  // ****************************************************************
  // The return's second cycle refills the pipeline, so no new instruction
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      busy <= 1'b0;
      sleep_state <= 1'b0;
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake_pin;
      wake_sync <= wake_meta;
      if (is_ret) begin
        busy <= 1'b1;
      end else if (cycle_en) begin
        busy <= 1'b0;
      end
      if (is_sleep) begin
        sleep_state <= 1'b1;
      end else if (wake_sync) begin
        sleep_state <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Avalon-MM slave, one wait state on every access
  // ****************************************************************
  assign access = avs_read || avs_write;
  assign avs_waitrequest = access && !bus_ack;
  assign wr_fire = avs_write && bus_ack;
  assign wr_acc = wr_fire && (avs_address == ADDR_ACC);
  assign wr_status = wr_fire && (avs_address == ADDR_STATUS);
  assign wr_ctrl = wr_fire && (avs_address == ADDR_CTRL);
  // Unmapped offsets read as zero and ignore writes
  assign rd_mux = (avs_address == ADDR_ACC) ? {24'h00_0000, accumulator} :
                  (avs_address == ADDR_STATUS) ? {27'h0, watchdog_expiry_n,
                                                  power_down_n, zero,
                                                  nibble_borrow_inverse, carry} :
                  (avs_address == ADDR_CTRL) ? {31'h0, exec_en} :
                  (avs_address == ADDR_STATE) ? {30'h0, busy, sleep_state} :
                  WORD_ZERO;

  // Acknowledge flop, read data and control register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bus_ack <= 1'b0;
      avs_readdata <= WORD_ZERO;
      exec_en <= 1'b1;
    end else begin
      bus_ack <= access && !bus_ack;
      if (avs_read && !bus_ack) begin
        avs_readdata <= rd_mux;
      end
      if (wr_ctrl) begin
        exec_en <= avs_writedata[CT_EXEC_EN];
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_ret_start;
    is_ret && !wr_status;
  endsequence
  sequence s_sleep_start;
    is_sleep;
  endsequence
  sequence s_ret_refill;
    busy [*4] ##1 !busy;
  endsequence

  property p_ret_acc;
    s_ret_start |=> accumulator == $past(instr_literal) && $stable(carry)
      && $stable(zero) && $stable(nibble_borrow_inverse);
  endproperty
  a_ret_acc: assert property (p_ret_acc) else $error("return literal wrong");

  property p_ret_pop;
    s_ret_start |=> stack_pop && pc_load && pc_value == $past(stack_top);
  endproperty
  a_ret_pop: assert property (p_ret_pop) else $error("return did not pop the stack");

  property p_ret_two;
    s_ret_start |=> s_ret_refill;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");

  property p_rot_left;
    exec && instr_op == OP_ROT_LEFT |=> carry == $past(file_rdata[7])
      && ($past(instr_dest) ? file_wdata : accumulator)
         == {$past(file_rdata[6:0]), $past(carry)};
  endproperty
  a_rot_left: assert property (p_rot_left) else $error("rotate left wrong");

  property p_dest;
    exec && (instr_op inside {OP_ROT_LEFT, OP_ROT_RIGHT, OP_REG_SUB})
      |=> file_we == $past(instr_dest) && file_waddr == $past(instr_faddr);
  endproperty
  a_dest: assert property (p_dest) else $error("destination select wrong");

  property p_rot_right;
    exec && instr_op == OP_ROT_RIGHT |=> carry == $past(file_rdata[0])
      && ($past(instr_dest) ? file_wdata : accumulator)
         == {$past(carry), $past(file_rdata[7:1])};
  endproperty
  a_rot_right: assert property (p_rot_right) else $error("rotate right wrong");

  property p_lit_sub;
    exec && instr_op == OP_LIT_SUB |=>
      accumulator == 8'($past(instr_literal) - $past(accumulator))
      && carry == ($past(accumulator) <= $past(instr_literal))
      && zero == (accumulator == BYTE_ZERO);
  endproperty
  a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

  property p_reg_sub;
    exec && instr_op == OP_REG_SUB |=>
      carry == ($past(accumulator) <= $past(file_rdata))
      && nibble_borrow_inverse == ($past(accumulator[3:0]) <= $past(file_rdata[3:0]));
  endproperty
  a_reg_sub: assert property (p_reg_sub) else $error("register subtract flags wrong");

  property p_sleep;
    s_sleep_start |=> watchdog_counter_clear && watchdog_prescaler_clear
      && !power_down_n && watchdog_expiry_n;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep status wrong");

  property p_halt;
    s_sleep_start |=> sleep_state && osc_stop && !instr_ready;
  endproperty
  a_halt: assert property (p_halt) else $error("sleep did not halt");

  property p_single;
    exec && (instr_op inside {OP_ROT_LEFT, OP_ROT_RIGHT, OP_LIT_SUB, OP_REG_SUB})
      |=> !busy;
  endproperty
  a_single: assert property (p_single) else $error("single-cycle op stalled");

endmodule // rrs_exec

`default_nettype wire

// >>> bench/cpu_return_rotate_subtract_exec_test.sv
`timescale 1ns/1ps
`default_nettype none

module cpu_return_rotate_subtract_exec_test import rrs_pkg::*;;
  logic clk_sys, rstn, avs_read, avs_write, instr_valid, instr_dest, watchdog_timeout, wake_pin;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  rrs_op_t instr_op;
  logic [DATA_W-1:0] instr_literal, file_rdata, file_wdata, accumulator, acc_m;
  logic [FADDR_W-1:0] instr_faddr, file_waddr;
  logic [PC_W-1:0] stack_top, pc_value;
  logic avs_waitrequest, instr_ready, file_we, stack_pop, pc_load, watchdog_counter_clear;
  logic watchdog_prescaler_clear, sleep_state, osc_stop, carry, nibble_borrow_inverse, zero;
  logic power_down_n, watchdog_expiry_n, c_m, dc_m, z_m, prev_ret;
  int fails = 0, n_tests = 0, cyc = 0, last_acc = 0, n;
  rrs_op_t ops[6] = '{OP_ROT_LEFT, OP_ROT_RIGHT, OP_LIT_SUB, OP_REG_SUB, OP_RETURN_LIT, OP_NONE};
  logic [ADDR_W-1:0] ra[5] = '{ADDR_ACC, ADDR_STATUS, ADDR_CTRL, ADDR_STATE, 5'h10};
  logic [31:0] rv[5] = '{32'h0, 32'h18, 32'h1, 32'h0, 32'h0};
  rrs_op_t op;

  rrs_exec rrs_exec_inst (
    .clk_sys, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .instr_valid, .instr_op, .instr_literal, .instr_faddr, .instr_dest,
    .instr_ready, .file_rdata, .file_we, .file_waddr, .file_wdata, .stack_top, .stack_pop,
    .pc_load, .pc_value, .watchdog_timeout, .wake_pin, .watchdog_counter_clear,
    .watchdog_prescaler_clear, .sleep_state, .osc_stop, .accumulator, .carry,
    .nibble_borrow_inverse, .zero, .power_down_n, .watchdog_expiry_n
  );

  // 20 MHz clock and a cycle count used to time instruction spacing
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;

  // ****************************************************************
  // Compare, bus and instruction helpers
  // ****************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Entered just after an edge; holds the request until waitrequest is seen low
  task automatic bus(input logic we, input logic [ADDR_W-1:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    int k;
    k = 0;
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= wd;
    do begin
      @(posedge clk_sys);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    d = avs_readdata;
    if (k >= 50) fails++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // Expected {carry, nibble flag, zero, result}
  function automatic logic [10:0] model(rrs_op_t o, logic [7:0] lit, logic [7:0] fr);
    logic [7:0] s;
    s = (o == OP_LIT_SUB) ? lit : fr;
    case (o)
      OP_ROT_LEFT: return {fr[7], dc_m, z_m, fr[6:0], c_m};
      OP_ROT_RIGHT: return {fr[0], dc_m, z_m, c_m, fr[7:1]};
      OP_LIT_SUB, OP_REG_SUB: return {acc_m <= s, acc_m[3:0] <= s[3:0], s == acc_m, s - acc_m};
      OP_RETURN_LIT: return {c_m, dc_m, z_m, lit};
      default: return {c_m, dc_m, z_m, acc_m};
    endcase
  endfunction

  // Offers one instruction, waits for it to be taken, checks the results
  task automatic exec(input rrs_op_t o, input logic [7:0] lit, input logic [6:0] fa,
                      input logic d, input logic [7:0] fr, input int gap);
    logic [10:0] r;
    logic [14:0] st;
    logic dst_reg;
    int k;
    r = model(o, lit, fr);
    st = 15'($urandom);
    dst_reg = d && (o == OP_ROT_LEFT || o == OP_ROT_RIGHT || o == OP_REG_SUB);
    k = 0;
    instr_valid <= 1'b1;
    instr_op <= o;
    instr_literal <= lit;
    instr_faddr <= fa;
    instr_dest <= d;
    file_rdata <= fr;
    stack_top <= st;
    do begin
      @(posedge clk_sys);
      k++;
    end while (instr_ready !== 1'b1 && k < 100);
    if (k >= 100) fails++;
    instr_valid <= 1'b0;
    if (gap > 0) chk_val(32'(cyc - last_acc), 32'(gap));
    last_acc = cyc;
    @(negedge clk_sys);
    if (!dst_reg) acc_m = r[7:0];
    {c_m, dc_m, z_m} = r[10:8];
    chk_val(accumulator, acc_m);
    chk_val({carry, nibble_borrow_inverse, zero}, {c_m, dc_m, z_m});
    chk_val(file_we, dst_reg);
    if (dst_reg) chk_val({file_waddr, file_wdata}, {fa, r[7:0]});
    chk_val({stack_pop, pc_load}, {2{o == OP_RETURN_LIT}});
    if (o == OP_RETURN_LIT) chk_val(pc_value, st);
    chk_val({watchdog_counter_clear, watchdog_prescaler_clear}, {2{o == OP_SLEEP}});
    @(posedge clk_sys);
  endtask

  // Hang guard, well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    stop_test();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {rstn, avs_read, avs_write, instr_valid, instr_dest, watchdog_timeout, wake_pin} = 7'h00;
    {avs_address, avs_writedata, instr_literal, file_rdata, instr_faddr, stack_top} = '0;
    instr_op = OP_NONE;
    void'($urandom(55599));
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, ra[i], 32'h0, rd);
      chk_val(rd, rv[i]);
    end
    $display("Reset values test done");
    // Bus writes: upper bits dropped, power flags read-only, state ignored
    bus(1'b1, ADDR_ACC, 32'hFFFF_FFA5, rd);
    bus(1'b0, ADDR_ACC, 32'h0, rd);
    chk_val(rd, 32'h0000_00A5);
    bus(1'b1, ADDR_STATUS, 32'h0000_0006, rd);
    bus(1'b0, ADDR_STATUS, 32'h0, rd);
    chk_val(rd, 32'h0000_001E);
    bus(1'b1, ADDR_STATE, 32'h0000_0003, rd);
    bus(1'b0, ADDR_STATE, 32'h0, rd);
    chk_val(rd, 32'h0);
    {acc_m, c_m, dc_m, z_m} = {8'hA5, 3'h3};
    $display("Register access test done");
    // Corner cases: rotate examples, equal operands, return then subtract
    exec(OP_ROT_LEFT, 8'h00, 7'h7F, 1'b0, 8'hE6, 0);
    exec(OP_ROT_RIGHT, 8'h00, 7'h00, 1'b1, 8'h01, 4);
    exec(OP_LIT_SUB, acc_m, 7'h00, 1'b0, 8'h00, 4);
    exec(OP_RETURN_LIT, 8'hFF, 7'h01, 1'b0, 8'h00, 4);
    exec(OP_REG_SUB, 8'h00, 7'h7F, 1'b1, 8'h10, 8);
    exec(OP_REG_SUB, 8'h00, 7'h05, 1'b0, 8'hFF, 4);
    $display("Corner case test done");
    // Random back-to-back stream of every instruction kind except sleep
    prev_ret = 1'b0;
    for (int i = 0; i < 60; i++) begin
      op = ops[$urandom_range(5)];
      exec(op, 8'($urandom), 7'($urandom), 1'($urandom), 8'($urandom),
           i == 0 ? 0 : (prev_ret ? 8 : 4));
      prev_ret = (op == OP_RETURN_LIT);
    end
    $display("Random stream test done");
    // Execution disabled: an offered instruction must not be taken
    bus(1'b1, ADDR_CTRL, 32'h0, rd);
    instr_valid <= 1'b1;
    instr_op <= OP_LIT_SUB;
    instr_literal <= acc_m + 8'h33;
    repeat (12) @(posedge clk_sys);
    instr_valid <= 1'b0;
    chk_val(accumulator, acc_m);
    bus(1'b1, ADDR_CTRL, 32'h1, rd);
    $display("Disabled execution test done");
    // Sleep after a watchdog expiry, then hold off, then wake
    watchdog_timeout <= 1'b1;
    @(posedge clk_sys);
    watchdog_timeout <= 1'b0;
    @(posedge clk_sys);
    chk_val(watchdog_expiry_n, 1'b0);
    exec(OP_SLEEP, 8'h00, 7'h00, 1'b0, 8'h00, 0);
    chk_val({power_down_n, watchdog_expiry_n, sleep_state, osc_stop}, 4'h7);
    instr_valid <= 1'b1;
    instr_op <= OP_ROT_LEFT;
    n = 0;
    repeat (20) begin
      @(posedge clk_sys);
      if (instr_ready !== 1'b0) n++;
    end
    chk_val(32'(n), 32'h0);
    chk_val(accumulator, acc_m);
    wake_pin <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (sleep_state !== 1'b0 && n < 50);
    wake_pin <= 1'b0;
    instr_valid <= 1'b0;
    @(posedge clk_sys);
    exec(OP_LIT_SUB, 8'($urandom), 7'h00, 1'b0, 8'h00, 0);
    chk_val(power_down_n, 1'b0);
    $display("Sleep test done");
    stop_test();
  end
endmodule // cpu_return_rotate_subtract_exec_test

`default_nettype wire
